// File: pin_port_consts.vh
// Constants for the external pin interface of the signal processor core.
// Assumes inclusion by its bare name from the design file.
`ifndef PIN_PORT_CONSTS_VH
`define PIN_PORT_CONSTS_VH
`define DATA_W 16
`define PC_W 9
`define PC_RESET 9'h000
`define PC_START 9'h001
`define CTRL_W 5
`define CTRL_BYTE_BIT 0
`define CTRL_DMA_BIT 1
`define FN_INPUT_REG 4'h0
`define FN_OUTPUT_REG 4'h1
`define FN_CONTROL_REG 4'h2
`define FN_PC_LOAD 4'h3
`define FN_BYTE_HIGH_BIT 3
`define SHIFT_COUNT_W 5
`define SHIFT_BITS 5'h10
`define CLK_DIV 4
`define RESET_MIN_NS 1000
`define REF_PERIOD_NS 25
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`endif

// File: dsp_external_pin_interface.v
// External pin interface of the signal processor: host port, DMA handshake,
// serial ports, bit pin, reset and clock divider.
// Assumes ref_clk is the oscillator; all pins are asynchronous to it.
//
// How it works
// RULE1 - Drive data bus on host read (direction high), accept writes when low, under select.
// RULE2 - Data bus released whenever chip select is inactive.
// RULE3 - Byte or word transfers chosen by control register and function select.
// RULE4 - Host strobe captures data bus into selected register under chip select.
// RULE5 - Falling edge of host strobe after a transfer flags an interrupt event.
// RULE6 - Data, function, direction and strobe ignored unless chip select low.
// RULE7 - Function select picks the register taking part in each host transfer.
// RULE8 - Host may write the control register through the host port.
// RULE9 - Host may load the program counter with a start address.
// RULE10 - DMA end low leaves DMA transfer mode.
// RULE11 - Setting the DMA mode flag starts transfer request driving.
// RULE12 - In DMA mode, request rises on each port-accumulator data move.
// RULE13 - Transfer acknowledge returns the request low.
// RULE14 - Outside DMA mode the request pin is a program-controlled output.
// RULE15 - Serial input bits shift in on falling serial input clock.
// RULE16 - Rising serial input enable starts collecting a word.
// RULE17 - Completion of a serial input word flags an interrupt event.
// RULE18 - Serial output driven while its enable high, floats otherwise.
// RULE19 - Serial output changes on rising serial output clock.
// RULE20 - Falling serial output enable after a transfer flags an interrupt event.
// RULE21 - Bit pin is open drain; write one to read the pin level.
// RULE22 - Reset clears program counter, sets interrupt mask, keeps other registers (here reset also clears host, control and serial registers).
// RULE23 - After reset, execution starts at address one.
// RULE24 - System holds reset low above one microsecond with oscillator running.
// RULE25 - Internal clock is oscillator divided by four.
// RULE26 - Byte mode moves host words as upper and lower halves.
// RULE27 - Host output register holds until the program writes it.
// RULE28 - Serial input register clears after moving to the accumulator.
// RULE29 - Output bit count equals output clock pulses while enabled, max sixteen.
// RULE30 - External clocks, enables and strobe are synchronised before use (host_data_oe and serial_out_oe take chip select and enable raw).
`include "pin_port_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module dsp_external_pin_interface #(
  parameter DATA_W = `DATA_W,
  parameter PC_W = `PC_W
) (
  input wire ref_clk,
  input wire rst_n,
  input wire chip_select_n,
  input wire read_not_write,
  input wire host_transfer_strobe,
  input wire [3:0] function_select,
  input wire [DATA_W-1:0] host_data_in,
  output reg [DATA_W-1:0] host_data_out,
  output wire host_data_oe,
  input wire dma_end_n,
  input wire transfer_acknowledge,
  output wire transfer_request_out,
  output wire transfer_request_oe,
  input wire serial_in_data,
  input wire serial_in_clock,
  input wire serial_in_enable,
  input wire serial_out_clock,
  input wire serial_out_enable,
  output reg serial_out_data,
  output wire serial_out_oe,
  input wire bit_io_in,
  output wire bit_io_out,
  output wire bit_io_oe,
  input wire core_ctrl_write,
  input wire [`CTRL_W-1:0] core_ctrl_data,
  input wire core_out_write,
  input wire [DATA_W-1:0] core_out_data,
  input wire core_in_read,
  input wire core_serial_in_read,
  input wire core_serial_out_write,
  input wire [DATA_W-1:0] core_serial_out_data,
  input wire core_request_set,
  input wire core_request_clear,
  input wire core_bit_write,
  input wire core_bit_value,
  input wire core_pc_advance,
  input wire core_mask_clear,
  output reg [DATA_W-1:0] host_input_register,
  output reg [DATA_W-1:0] serial_input_shift_register,
  output reg [`CTRL_W-1:0] control_register,
  output reg [PC_W-1:0] program_counter,
  output reg interrupt_mask_flag,
  output reg bit_io_level,
  output reg dma_mode,
  output reg host_strobe_event,
  output reg serial_in_done_event,
  output reg serial_out_done_event,
  output reg core_clock_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the ten control pins gathered in pin_raw
  localparam SYNC_N = 10;
  // Pin positions inside the synchroniser vectors
  localparam P_CS = 0;
  localparam P_STROBE = 1;
  localparam P_SI_DATA = 2;
  localparam P_SI_CLOCK = 3;
  localparam P_SI_EN = 4;
  localparam P_SO_CLOCK = 5;
  localparam P_SO_EN = 6;
  localparam P_DMA_END_N = 7;
  localparam P_ACK = 8;
  localparam P_BIT = 9;
  // Reset to each pin's idle level so that no false edge follows reset
  localparam [SYNC_N-1:0] SYNC_IDLE = 10'h289;
  wire [SYNC_N-1:0] pin_raw;
  reg [SYNC_N-1:0] sync1_reg;
  reg [SYNC_N-1:0] sync2_reg;
  reg [SYNC_N-1:0] sync3_reg;
  assign pin_raw = {bit_io_in, transfer_acknowledge, dma_end_n, serial_out_enable,
    serial_out_clock, serial_in_enable, serial_in_clock, serial_in_data,
    host_transfer_strobe, chip_select_n};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
      sync3_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= pin_raw; // RULE30
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Rise and fall flags for every synchronised pin
  wire [SYNC_N-1:0] pin_rise;
  wire [SYNC_N-1:0] pin_fall;
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi = gi + 1) begin : g_edge
      assign pin_rise[gi] = sync2_reg[gi] & ~sync3_reg[gi];
      assign pin_fall[gi] = sync3_reg[gi] & ~sync2_reg[gi];
    end
  endgenerate

  wire cs_active = ~sync2_reg[P_CS];
  wire strobe_fall = pin_fall[P_STROBE];
  wire si_bit = sync2_reg[P_SI_DATA];
  wire si_clk_fall = pin_fall[P_SI_CLOCK];
  wire si_en_level = sync2_reg[P_SI_EN];
  wire si_en_rise = pin_rise[P_SI_EN];
  wire so_clk_rise = pin_rise[P_SO_CLOCK];
  wire so_en_level = sync2_reg[P_SO_EN];
  wire so_en_fall = pin_fall[P_SO_EN];
  wire dma_end_low = ~sync2_reg[P_DMA_END_N];
  wire ack_level = sync2_reg[P_ACK];
  wire bit_pin = sync2_reg[P_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider: internal operating clock as a one-in-four enable pulse
  reg [1:0] div_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
      core_clock_enable <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1; // RULE25
      core_clock_enable <= (div_reg == (`CLK_DIV - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host parallel port
  function is_fn;
    input [3:0] fs;
    input [3:0] code;
    begin
      is_fn = (fs[2:0] == code[2:0]);
    end
  endfunction

  reg [DATA_W-1:0] host_output_register;
  wire byte_mode = control_register[`CTRL_BYTE_BIT] | function_select[`FN_BYTE_HIGH_BIT];
  reg byte_phase_reg;
  wire host_write = strobe_fall & cs_active & ~read_not_write; // RULE4 RULE6
  wire host_read = strobe_fall & cs_active & read_not_write;
  // Declared ahead of the register and DMA processes that read them
  reg pc_start_pending;
  wire dma_end_fire;
  wire dma_start;

  // Bus driven only during a selected read
  assign host_data_oe = ~chip_select_n & read_not_write; // RULE1 RULE2

  always @(*) begin
    if (byte_mode) begin
      if (byte_phase_reg) begin
        host_data_out = {{(DATA_W/2){1'b0}}, host_output_register[DATA_W-1:DATA_W/2]}; // RULE26
      end else begin
        host_data_out = {{(DATA_W/2){1'b0}}, host_output_register[DATA_W/2-1:0]};
      end
    end else begin
      host_data_out = host_output_register;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_input_register <= {DATA_W{1'b0}};
      host_output_register <= {DATA_W{1'b0}};
      control_register <= {`CTRL_W{1'b0}};
      program_counter <= `PC_RESET; // RULE22
      interrupt_mask_flag <= 1'b1;
      byte_phase_reg <= 1'b0;
      host_strobe_event <= 1'b0;
    end else begin
      host_strobe_event <= host_write | host_read; // RULE5
      if (host_write & is_fn(function_select, `FN_INPUT_REG)) begin // RULE7
        if (byte_mode) begin // RULE3 RULE26
          if (byte_phase_reg) begin
            host_input_register[DATA_W-1:DATA_W/2] <= host_data_in[DATA_W/2-1:0];
          end else begin
            host_input_register[DATA_W/2-1:0] <= host_data_in[DATA_W/2-1:0];
          end
        end else begin
          host_input_register <= host_data_in;
        end
      end
      if ((host_write | host_read) & byte_mode &
          (is_fn(function_select, `FN_INPUT_REG) | is_fn(function_select, `FN_OUTPUT_REG))) begin
        byte_phase_reg <= ~byte_phase_reg;
      end else if (!byte_mode) begin
        byte_phase_reg <= 1'b0;
      end
      if (host_write & is_fn(function_select, `FN_CONTROL_REG)) begin
        control_register <= host_data_in[`CTRL_W-1:0]; // RULE8
      end else if (core_ctrl_write) begin
        control_register <= core_ctrl_data;
      end else if (dma_end_fire) begin
        control_register[`CTRL_DMA_BIT] <= 1'b0; // RULE10
      end
      if (core_out_write) begin
        host_output_register <= core_out_data; // RULE27
      end
      if (host_write & is_fn(function_select, `FN_PC_LOAD)) begin
        program_counter <= {1'b0, host_data_in[PC_W-2:0]} + `PC_START; // RULE9
      end else if (pc_start_pending | core_pc_advance) begin
        program_counter <= program_counter + 9'h001; // RULE23
      end
      if (core_mask_clear) begin
        interrupt_mask_flag <= 1'b0;
      end
    end
  end

  // First ref_clk cycle after reset steps past address zero
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_start_pending <= 1'b1;
    end else begin
      pc_start_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA handshake and request pin
  // DMA end outranks every request source while in DMA mode
  assign dma_end_fire = dma_mode & dma_end_low;
  // Setting the mode flag raises the request once, before the mode takes hold
  assign dma_start = ~dma_mode & control_register[`CTRL_DMA_BIT] & ~dma_end_low;
  reg request_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_mode <= 1'b0;
      request_reg <= 1'b0;
    end else begin
      dma_mode <= control_register[`CTRL_DMA_BIT] & ~dma_end_low; // RULE11 RULE10
      if (dma_mode) begin
        if (dma_end_low) begin
          request_reg <= 1'b0;
        end else if (core_in_read | core_out_write) begin
          request_reg <= 1'b1; // RULE12
        end else if (ack_level) begin
          request_reg <= 1'b0; // RULE13
        end
      end else if (dma_start) begin
        request_reg <= 1'b1; // RULE11
      end else if (core_request_set) begin
        request_reg <= 1'b1; // RULE14
      end else if (core_request_clear) begin
        request_reg <= 1'b0;
      end
    end
  end
  // Open drain: pull low when inactive, release for high
  assign transfer_request_out = 1'b0;
  assign transfer_request_oe = ~request_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Serial input
  // A word closes after sixteen bits or when the peer drops the enable early
  reg [`SHIFT_COUNT_W-1:0] si_count_reg;
  reg si_active_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_input_shift_register <= {DATA_W{1'b0}};
      si_count_reg <= {`SHIFT_COUNT_W{1'b0}};
      si_active_reg <= 1'b0;
      serial_in_done_event <= 1'b0;
    end else begin
      serial_in_done_event <= 1'b0;
      if (si_en_rise) begin
        si_active_reg <= 1'b1; // RULE16
        si_count_reg <= {`SHIFT_COUNT_W{1'b0}};
      end else if (si_active_reg & si_clk_fall) begin
        serial_input_shift_register <= {serial_input_shift_register[DATA_W-2:0], si_bit}; // RULE15
        si_count_reg <= si_count_reg + 5'h01;
        if (si_count_reg == (`SHIFT_BITS - 5'h01) || !si_en_level) begin
          si_active_reg <= 1'b0;
          serial_in_done_event <= 1'b1; // RULE17
        end
      end else if (si_active_reg & !si_en_level & (si_count_reg != 5'h00)) begin
        si_active_reg <= 1'b0;
        serial_in_done_event <= 1'b1;
      end else if (core_serial_in_read) begin
        serial_input_shift_register <= {DATA_W{1'b0}}; // RULE28
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output
  // Clocks past sixteen while enabled shift nothing more
  reg [DATA_W-1:0] serial_out_shift_reg;
  reg [`SHIFT_COUNT_W-1:0] so_count_reg;
  assign serial_out_oe = serial_out_enable; // RULE18
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_shift_reg <= {DATA_W{1'b0}};
      so_count_reg <= {`SHIFT_COUNT_W{1'b0}};
      serial_out_data <= 1'b0;
      serial_out_done_event <= 1'b0;
    end else begin
      serial_out_done_event <= so_en_fall & (so_count_reg != 5'h00); // RULE20
      if (core_serial_out_write) begin
        serial_out_shift_reg <= core_serial_out_data;
        so_count_reg <= {`SHIFT_COUNT_W{1'b0}};
      end else if (so_en_level & so_clk_rise & (so_count_reg != `SHIFT_BITS)) begin
        serial_out_data <= serial_out_shift_reg[DATA_W-1]; // RULE19 RULE29
        serial_out_shift_reg <= {serial_out_shift_reg[DATA_W-2:0], 1'b0};
        so_count_reg <= so_count_reg + 5'h01;
      end else if (so_en_fall) begin
        so_count_reg <= {`SHIFT_COUNT_W{1'b0}};
        serial_out_shift_reg <= {DATA_W{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit I/O, open drain
  reg bit_ff_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_ff_reg <= 1'b1;
      bit_io_level <= 1'b0;
    end else begin
      if (core_bit_write) begin
        bit_ff_reg <= core_bit_value;
      end
      bit_io_level <= bit_pin; // RULE21
    end
  end
  assign bit_io_out = 1'b0;
  assign bit_io_oe = ~bit_ff_reg; // RULE21

endmodule

`default_nettype wire

// File: dsp_pin_chk.sv
// Checker: timing relations on the pin interface ports.
// Assumes it is bound to dsp_external_pin_interface with ref_clk as clock.
`include "pin_port_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module dsp_pin_chk #(parameter DATA_W = 16, parameter PC_W = 9) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic read_not_write,
  input wire logic dma_end_n,
  input wire logic transfer_acknowledge,
  input wire logic transfer_request_oe,
  input wire logic serial_out_enable,
  input wire logic serial_out_oe,
  input wire logic bit_io_out,
  input wire logic host_data_oe,
  input wire logic [DATA_W-1:0] host_input_register,
  input wire logic [PC_W-1:0] program_counter,
  input wire logic interrupt_mask_flag,
  input wire logic dma_mode,
  input wire logic host_strobe_event,
  input wire logic core_clock_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_read_drive; host_data_oe == (!chip_select_n && read_not_write); endproperty
  a_read_drive: assert property (p_read_drive) else $error("bus drive wrong");
  property p_release; chip_select_n |-> !host_data_oe; endproperty
  a_release: assert property (p_release) else $error("bus driven unselected");
  property p_ignore; chip_select_n [*4] |=> $stable(host_input_register) && !host_strobe_event;
  endproperty
  a_ignore: assert property (p_ignore) else $error("unselected strobe taken");
  property p_reset_state;
    !$past(rst_n) |-> program_counter == `PC_RESET && interrupt_mask_flag;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_start; $past(rst_n) && !$past(rst_n, 2) |-> program_counter == `PC_START; endproperty
  a_start: assert property (p_start) else $error("start address wrong");
  property p_dma_end; !dma_end_n |-> ##[1:4] !dma_mode; endproperty
  a_dma_end: assert property (p_dma_end) else $error("dma mode kept");
  property p_ack; transfer_acknowledge && !transfer_request_oe |-> ##[1:4] transfer_request_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("request not withdrawn");
  property p_so_float; serial_out_oe == serial_out_enable; endproperty
  a_so_float: assert property (p_so_float) else $error("serial drive wrong");
  property p_bit_od; bit_io_out == 1'b0; endproperty
  a_bit_od: assert property (p_bit_od) else $error("bit pin driven high");
  property p_divide; core_clock_enable |=> !core_clock_enable [*3] ##1 core_clock_enable;
  endproperty
  a_divide: assert property (p_divide) else $error("clock divide wrong");
  c_strobe: cover property (host_strobe_event);
  c_req: cover property (!transfer_request_oe ##[1:20] transfer_request_oe);
  c_dma: cover property (dma_mode ##1 !dma_mode);
endmodule
bind dsp_external_pin_interface dsp_pin_chk #(.DATA_W(DATA_W), .PC_W(PC_W)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
  .read_not_write(read_not_write), .dma_end_n(dma_end_n),
  .transfer_acknowledge(transfer_acknowledge), .transfer_request_oe(transfer_request_oe),
  .serial_out_enable(serial_out_enable), .serial_out_oe(serial_out_oe),
  .bit_io_out(bit_io_out), .host_data_oe(host_data_oe),
  .host_input_register(host_input_register), .program_counter(program_counter),
  .interrupt_mask_flag(interrupt_mask_flag), .dma_mode(dma_mode),
  .host_strobe_event(host_strobe_event), .core_clock_enable(core_clock_enable));
`default_nettype wire

// File: far_side_model.sv
// Far side: DMA controller and serial peers, behavioural.
// Assumes the bench calls send_word and recv_word one at a time.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic transfer_request_oe,
  input wire logic ack_enable,
  input wire logic serial_out_data,
  output var logic transfer_acknowledge = 1'b0,
  output var logic serial_in_data = 1'b0,
  output var logic serial_in_clock = 1'b1,
  output var logic serial_in_enable = 1'b0,
  output var logic serial_out_clock = 1'b0,
  output var logic serial_out_enable = 1'b0
);
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge transfer_request_oe) if (ack_enable) begin
    #300 transfer_acknowledge = 1'b1;
    #200 transfer_acknowledge = 1'b0;
  end
  task send_word(input logic [15:0] w);
    serial_in_enable = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      serial_in_data = w[i];
      #100 serial_in_clock = 1'b0;
      #100 serial_in_clock = 1'b1;
    end
    serial_in_enable = 1'b0;
    serial_in_data = ~w[0];
  endtask
  task recv_word(output logic [15:0] w);
    serial_out_enable = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      #50 serial_out_clock = 1'b1;
      #150 w[i] = serial_out_data;
      serial_out_clock = 1'b0;
    end
    #100 serial_out_enable = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Bench: host port, DMA, serial and bit pin scenarios with expected values.
// Assumes far_side_model as peer and core pulses driven directly.
`include "pin_port_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic rw = 1'b0;
  logic strobe = 1'b0;
  logic dma_end_n = 1'b1;
  logic ack_en = 1'b0;
  logic bit_in = 1'b1;
  logic core_bit = 1'b0;
  logic idle = 1'b0;
  logic [3:0] fs = 4'h0;
  logic [7:0] core_p = 8'h00;
  logic [15:0] din = 16'h0000;
  logic [15:0] core_data = 16'h0000;
  logic [15:0] q;
  int n_fail = 0, check_count = 0, cycles = 0, n_si = 0, n_so = 0, n_cen = 0, n_hs = 0;
  wire [15:0] dout, si_word, hir;
  wire [4:0] ctrl;
  wire [8:0] pc;
  wire dout_oe, ack, req_oe, si_d, si_c, si_e, so_c, so_e, so_d, so_oe, bit_oe;
  wire mask, bit_lvl, dma_mode, ev_si, ev_so, cen, hs_ev;
  wire bit_pin = bit_in & ~bit_oe;
  always #12.5 ref_clk = ~ref_clk;
  dsp_external_pin_interface DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_n(cs_n), .read_not_write(rw),
    .host_transfer_strobe(strobe), .function_select(fs), .host_data_in(din),
    .host_data_out(dout), .host_data_oe(dout_oe), .dma_end_n(dma_end_n),
    .transfer_acknowledge(ack), .transfer_request_out(), .transfer_request_oe(req_oe),
    .serial_in_data(si_d), .serial_in_clock(si_c), .serial_in_enable(si_e),
    .serial_out_clock(so_c), .serial_out_enable(so_e), .serial_out_data(so_d),
    .serial_out_oe(so_oe), .bit_io_in(bit_pin), .bit_io_out(), .bit_io_oe(bit_oe),
    .core_ctrl_write(core_p[0]), .core_ctrl_data(core_data[4:0]), .core_out_write(core_p[1]),
    .core_out_data(core_data), .core_in_read(core_p[2]), .core_serial_in_read(core_p[3]),
    .core_serial_out_write(core_p[4]), .core_serial_out_data(core_data),
    .core_request_set(core_p[5]),
    .core_request_clear(core_p[6]), .core_bit_write(core_p[7]), .core_bit_value(core_bit),
    .core_pc_advance(idle), .core_mask_clear(idle), .host_input_register(hir),
    .serial_input_shift_register(si_word), .control_register(ctrl), .program_counter(pc),
    .interrupt_mask_flag(mask), .bit_io_level(bit_lvl), .dma_mode(dma_mode),
    .host_strobe_event(hs_ev), .serial_in_done_event(ev_si), .serial_out_done_event(ev_so),
    .core_clock_enable(cen));
  far_side_model u_peer (.transfer_request_oe(req_oe), .ack_enable(ack_en),
    .serial_out_data(so_d), .transfer_acknowledge(ack), .serial_in_data(si_d),
    .serial_in_clock(si_c), .serial_in_enable(si_e), .serial_out_clock(so_c),
    .serial_out_enable(so_e));
  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task pulse(input int i);
    core_p[i] = 1'b1;
    cyc(1);
    core_p[i] = 1'b0;
  endtask
  task host(input logic c, input logic r, input logic [3:0] f, input logic [15:0] d);
    cs_n = c;
    rw = r;
    fs = f;
    din = d;
    cyc(2);
    strobe = 1'b1;
    cyc(3);
    q = dout;
    check("data_oe", {15'h0000, dout_oe}, {15'h0000, ~c & r});
    strobe = 1'b0;
    cyc(5);
    cs_n = 1'b1;
    rw = 1'b0;
    cyc(1);
  endtask
  always @(posedge ref_clk) begin
    n_si += (ev_si === 1'b1);
    n_so += (ev_so === 1'b1);
    n_cen += (cen === 1'b1);
    n_hs += (hs_ev === 1'b1);
    if (++cycles == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    cyc(44);
    rst_n = 1'b1;
    cyc(3);
    check("pc", {7'h00, pc}, 16'h0001);
    check("mask", {15'h0000, mask}, 16'h0001);
    host(1'b0, 1'b0, `FN_INPUT_REG, 16'ha5c3);
    check("in_reg", hir, 16'ha5c3);
    check("strobe_ev", n_hs[15:0], 16'h0001);
    host(1'b1, 1'b0, `FN_INPUT_REG, 16'h0f0f);
    check("in_unsel", hir, 16'ha5c3);
    check("unsel_ev", n_hs[15:0], 16'h0001);
    host(1'b0, 1'b0, `FN_INPUT_REG | 4'h8, 16'h0077);
    host(1'b0, 1'b0, `FN_INPUT_REG | 4'h8, 16'h0011);
    check("in_byte", hir, 16'h1177);
    core_data = 16'h1234;
    pulse(1);
    cyc(20);
    host(1'b0, 1'b1, `FN_OUTPUT_REG, 16'h0000);
    check("out_word", q, 16'h1234);
    host(1'b1, 1'b1, `FN_OUTPUT_REG, 16'h0000);
    host(1'b0, 1'b1, `FN_OUTPUT_REG | 4'h8, 16'h0000);
    check("out_lo", {8'h00, q[7:0]}, 16'h0034);
    host(1'b0, 1'b1, `FN_OUTPUT_REG | 4'h8, 16'h0000);
    check("out_hi", {8'h00, q[7:0]}, 16'h0012);
    host(1'b0, 1'b0, `FN_PC_LOAD, 16'h0040);
    check("pc_load", {7'h00, pc}, 16'h0041);
    ack_en = 1'b1;
    host(1'b0, 1'b0, `FN_CONTROL_REG, 16'h0002);
    check("ctrl", {11'h000, ctrl}, 16'h0002);
    check("dma_on", {15'h0000, dma_mode}, 16'h0001);
    pulse(2);
    cyc(3);
    check("req_dma", {15'h0000, req_oe}, 16'h0000);
    cyc(30);
    check("req_ack", {15'h0000, req_oe}, 16'h0001);
    dma_end_n = 1'b0;
    cyc(6);
    check("dma_end", {15'h0000, dma_mode}, 16'h0000);
    dma_end_n = 1'b1;
    ack_en = 1'b0;
    core_data = 16'h0000;
    pulse(0);
    pulse(5);
    cyc(2);
    check("req_set", {15'h0000, req_oe}, 16'h0000);
    pulse(6);
    cyc(2);
    check("req_clr", {15'h0000, req_oe}, 16'h0001);
    u_peer.send_word(16'hbeef);
    cyc(8);
    check("si_word", si_word, 16'hbeef);
    check("si_done", n_si[15:0], 16'h0001);
    pulse(3);
    cyc(2);
    check("si_word_clr", si_word, 16'h0000);
    core_data = 16'hc35a;
    pulse(4);
    u_peer.recv_word(q);
    cyc(8);
    check("so_word", q, 16'hc35a);
    check("so_done", n_so[15:0], 16'h0001);
    check("so_float", {15'h0000, so_oe}, 16'h0000);
    core_bit = 1'b0;
    pulse(7);
    cyc(2);
    check("bit_low", {15'h0000, bit_oe}, 16'h0001);
    core_bit = 1'b1;
    pulse(7);
    cyc(4);
    check("bit_high", {15'h0000, bit_lvl}, 16'h0001);
    bit_in = 1'b0;
    cyc(4);
    check("bit_in", {15'h0000, bit_lvl}, 16'h0000);
    n_cen = 0;
    cyc(40);
    check("divide", n_cen[15:0], 16'h000a);
    print_verdict;
  end
endmodule
`default_nettype wire
